// ### design/sysref_pkg.sv
// Constants, types and decode functions for output sync and align pulse gen
// What this block does
// - First synthesizer lock after reset auto-syncs all channel dividers, only once.
// - While the sync bit is set, all channels not ignoring sync are held.
// - Software sets then clears sync bit; sync happens on its falling transition.
// - New coarse phase offsets take effect only at the next output sync.
// - Two-bit mode: 00 direct external, 01 retimed external, 1x internal generator.
// - Direct mode routes external input straight out; requests ignored in external modes.
// - Retimed mode resamples external input on oscillator or feedback clock, bit selected.
// - Internal mode takes requests from the request pin or a software bit.
// - Generator clock is oscillator or feedback; fixed two times 16-bit divider.
// - Divider value accepts any integer from zero to 65535.
// - Generator pulses are always aligned to the divider, whatever the request timing.
// - One control bit picks software bits or request pin as request source.
// - Software N-shot starts on trigger bit rise; hardware clears it when done.
// - Software continuous runs while trigger bit is one, stops when cleared.
// - Pin level N-shot starts on rising pin; party lowers pin before next.
// - Pin level continuous starts on rising pin and stops when pin goes low.
// - Pin edge mode: trigger bit picks rising or falling edge as start.
// - Edge N-shot ignores pin falling and new edges until the sequence ends.
// - Output mode: 00 N-shot, 01 continuous, 10 invalid, 11 stop holds low.
// - Count code gives 1,2,4,6,8 pulses, 110 and up one; then low.
// - Continuous output is a 1010 train at input rate over twice K.
package sysref_pkg;
    localparam int NUM_CH = 14;
    localparam int ADDR_W = 13;
    // Register offsets
    localparam logic [12:0] OFS_OUT_SYNC = 13'h032a;
    localparam logic [12:0] OFS_IGN_LO = 13'h032b;
    localparam logic [12:0] OFS_IGN_HI = 13'h032c;
    localparam logic [12:0] OFS_KDIV_LO = 13'h0400;
    localparam logic [12:0] OFS_KDIV_HI = 13'h0401;
    localparam logic [12:0] OFS_REQ_TRIG = 13'h0402;
    localparam logic [12:0] OFS_MODE = 13'h0403;
    // Field positions
    localparam int SYNC_BIT = 0;
    localparam int REQ_SRC_BIT = 7;
    localparam int TRIG_TYPE_BIT = 6;
    localparam int TRIG_BIT = 5;
    localparam int RETIME_SEL_BIT = 4;
    localparam int GEN_BUSY_BIT = 0;
    localparam int SRC_MSB = 7;
    localparam int SRC_LSB = 6;
    localparam int OUT_MSB = 5;
    localparam int OUT_LSB = 4;
    localparam int CNT_MSB = 3;
    localparam int CNT_LSB = 1;
    localparam int SWREQ_BIT = 0;
    // Values after reset
    localparam logic [7:0] RST_OUT_SYNC = 8'h00;
    localparam logic [7:0] RST_IGN_LO = 8'h00;
    localparam logic [7:0] RST_IGN_HI = 8'h00;
    localparam logic [15:0] RST_KDIV = 16'h0000;
    localparam logic [7:0] RST_REQ_TRIG = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;

    typedef enum logic [1:0] {
        OUT_NSHOT = 2'b00,
        OUT_CONT = 2'b01,
        OUT_INVALID = 2'b10,
        OUT_STOP = 2'b11
    } out_mode_t;

    typedef enum logic {
        GEN_IDLE = 1'b0,
        GEN_RUN = 1'b1
    } gen_state_t;

    // Generator configuration decoded from the control registers
    typedef struct packed {
        logic [1:0] src_mode;
        out_mode_t out_mode;
        logic [2:0] count_code;
        logic req_from_pin;
        logic edge_trig;
        logic trig_bit;
        logic retime_sel;
    } gen_cfg_t;

    // N-shot pulse count from the three-bit count code
    function automatic logic [3:0] nshot_pulses(input logic [2:0] code);
        case (code)
            3'h2: nshot_pulses = 4'h2;
            3'h3: nshot_pulses = 4'h4;
            3'h4: nshot_pulses = 4'h6;
            3'h5: nshot_pulses = 4'h8;
            default: nshot_pulses = 4'h1;
        endcase
    endfunction
endpackage

// ### design/align_divider.sv
// Pattern generator clock divider: fixed two times programmable K
`timescale 1ns/1ps
module align_divider (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Control
    input wire logic tick,
    input wire logic restart,
    input wire logic [15:0] k_value,
    // Half-period strobe
    output logic half_edge
);
    import sysref_pkg::*;

    logic [15:0] cnt_q, cnt_d;
    logic edge_q, edge_d;
    logic [15:0] k_eff;

    // The fixed halving and K combine into one count: a half period lasts
    // K input ticks, so a full period is 2K; K of zero behaves as one
    always_comb begin
        k_eff = (k_value == 16'h0000) ? 16'h0001 : k_value;
        cnt_d = cnt_q;
        edge_d = 1'b0;
        if (restart) begin
            cnt_d = 16'h0000;
        end else if (tick) begin
            if (cnt_q >= k_eff - 16'h0001) begin
                cnt_d = 16'h0000;
                edge_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cnt_q <= 16'h0000;
            edge_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            edge_q <= edge_d;
        end
    end

    assign half_edge = edge_q;
endmodule

// ### design/channel_sync_ctrl.sv
// Channel divider hold and release on output sync
`timescale 1ns/1ps
module channel_sync_ctrl (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Sync sources
    input wire logic sync_bit,
    input wire logic auto_sync,
    input wire logic [sysref_pkg::NUM_CH-1:0] ignore_sync,
    // Channel side
    output logic [sysref_pkg::NUM_CH-1:0] hold,
    output logic release_pulse
);
    import sysref_pkg::*;

    logic [NUM_CH-1:0] hold_q, hold_d;
    logic rel_q, rel_d;
    logic prev_q, prev_d;

    // Auto sync holds every channel for one cycle; software sync spares
    // the channels that ignore it
    always_comb begin
        prev_d = sync_bit;
        hold_d = auto_sync ? '1 : ({NUM_CH{sync_bit}} & ~ignore_sync);
        rel_d = (prev_q & ~sync_bit) | auto_sync;
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            hold_q <= '0;
            rel_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            hold_q <= hold_d;
            rel_q <= rel_d;
            prev_q <= prev_d;
        end
    end

    assign hold = hold_q;
    assign release_pulse = rel_q;
endmodule

// ### design/sysref_sync_top.sv
// Output sync control and align pulse source selection and generator
`timescale 1ns/1ps
module sysref_sync_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register access from the serial control port
    input wire logic [sysref_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Clock front end, enables on clk_sys
    input wire logic osc_tick,
    input wire logic fb_tick,
    // Pins and loop status, asynchronous
    input wire logic synth_lock,
    input wire logic external_align_input,
    input wire logic align_pulse_request_pin,
    // Distribution side
    output logic align_out,
    output logic [sysref_pkg::NUM_CH-1:0] channel_hold,
    output logic channel_phase_apply
);
    import sysref_pkg::*;

    // Registers
    logic [7:0] sync_ctl_q, sync_ctl_d;
    logic [7:0] ign_lo_q, ign_lo_d;
    logic [7:0] ign_hi_q, ign_hi_d;
    logic [15:0] kdiv_q, kdiv_d;
    logic [7:0] trig_q, trig_d;
    logic [7:0] mode_q, mode_d;
    logic [7:0] rdata_q, rdata_d;
    // Synchronisers
    logic [1:0] lock_sq, ext_sq, pin_sq;
    logic lock_s, ext_s, pin_s;
    // Request and generator state
    logic pin_prev_q, pin_prev_d;
    logic sw_prev_q, sw_prev_d;
    logic first_done_q, first_done_d;
    logic auto_q, auto_d;
    gen_state_t state_q, state_d;
    logic gen_out_q, gen_out_d;
    logic [3:0] pulses_q, pulses_d;
    logic ret_q, ret_d;
    logic out_q, out_d;
    // Decoded and combinational
    gen_cfg_t cfg;
    logic gen_tick, div_edge, internal, sw_level, start, stop_level;
    logic nshot_done;
    logic [3:0] n_target;
    logic [NUM_CH-1:0] ignore_vec;
    logic rel_pulse;

    // Field decode into one carrier
    always_comb begin
        cfg.src_mode = mode_q[SRC_MSB:SRC_LSB];
        cfg.out_mode = out_mode_t'(mode_q[OUT_MSB:OUT_LSB]);
        cfg.count_code = mode_q[CNT_MSB:CNT_LSB];
        cfg.req_from_pin = trig_q[REQ_SRC_BIT];
        cfg.edge_trig = trig_q[TRIG_TYPE_BIT];
        cfg.trig_bit = trig_q[TRIG_BIT];
        cfg.retime_sel = trig_q[RETIME_SEL_BIT];
    end

    assign ignore_vec = {ign_hi_q[NUM_CH-9:0], ign_lo_q};
    assign internal = cfg.src_mode[1];
    assign n_target = nshot_pulses(cfg.count_code);
    // Generator and retimer share one clock choice: feedback or oscillator
    assign gen_tick = cfg.retime_sel ? fb_tick : osc_tick;

    // Two-stage synchronisers for every asynchronous input
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            lock_sq <= 2'h0;
            ext_sq <= 2'h0;
            pin_sq <= 2'h0;
        end else begin
            lock_sq <= {lock_sq[0], synth_lock};
            ext_sq <= {ext_sq[0], external_align_input};
            pin_sq <= {pin_sq[0], align_pulse_request_pin};
        end
    end
    assign lock_s = lock_sq[1];
    assign ext_s = ext_sq[1];
    assign pin_s = pin_sq[1];

    // Register file: writes, and the hardware clear of the request bits.
    // A write in the same cycle as the clear wins, so no request is lost.
    always_comb begin
        sync_ctl_d = sync_ctl_q;
        ign_lo_d = ign_lo_q;
        ign_hi_d = ign_hi_q;
        kdiv_d = kdiv_q;
        trig_d = trig_q;
        mode_d = mode_q;
        if (nshot_done && !cfg.req_from_pin) begin
            trig_d[TRIG_BIT] = 1'b0;
            mode_d[SWREQ_BIT] = 1'b0;
        end
        if (reg_wr) begin
            case (reg_addr)
                OFS_OUT_SYNC: sync_ctl_d = reg_wdata;
                OFS_IGN_LO: ign_lo_d = reg_wdata;
                OFS_IGN_HI: ign_hi_d = reg_wdata;
                OFS_KDIV_LO: kdiv_d[7:0] = reg_wdata;
                OFS_KDIV_HI: kdiv_d[15:8] = reg_wdata;
                OFS_REQ_TRIG: trig_d = reg_wdata;
                OFS_MODE: mode_d = reg_wdata;
                default: ;
            endcase
        end
    end

    // Readback; the busy bit shows the generator state, unmapped reads zero
    always_comb begin
        case (reg_addr)
            OFS_OUT_SYNC: rdata_d = sync_ctl_q;
            OFS_IGN_LO: rdata_d = ign_lo_q;
            OFS_IGN_HI: rdata_d = ign_hi_q;
            OFS_KDIV_LO: rdata_d = kdiv_q[7:0];
            OFS_KDIV_HI: rdata_d = kdiv_q[15:8];
            OFS_REQ_TRIG: rdata_d = {trig_q[7:1], state_q == GEN_RUN};
            OFS_MODE: rdata_d = mode_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sync_ctl_q <= RST_OUT_SYNC;
            ign_lo_q <= RST_IGN_LO;
            ign_hi_q <= RST_IGN_HI;
            kdiv_q <= RST_KDIV;
            trig_q <= RST_REQ_TRIG;
            mode_q <= RST_MODE;
            rdata_q <= 8'h00;
        end else begin
            sync_ctl_q <= sync_ctl_d;
            ign_lo_q <= ign_lo_d;
            ign_hi_q <= ign_hi_d;
            kdiv_q <= kdiv_d;
            trig_q <= trig_d;
            mode_q <= mode_d;
            rdata_q <= rdata_d;
        end
    end

    // One automatic sync on the first lock; later lock changes do nothing
    always_comb begin
        first_done_d = first_done_q | lock_s;
        auto_d = lock_s & ~first_done_q;
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            first_done_q <= 1'b0;
            auto_q <= 1'b0;
        end else begin
            first_done_q <= first_done_d;
            auto_q <= auto_d;
        end
    end

    // Divider hold and release; release also loads new coarse phases
    channel_sync_ctrl u_chan_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .sync_bit(sync_ctl_q[SYNC_BIT]),
        .auto_sync(auto_q),
        .ignore_sync(ignore_vec),
        .hold(channel_hold),
        .release_pulse(rel_pulse)
    );
    assign channel_phase_apply = rel_pulse;

    // Generator timebase, realigned with the channel dividers on each sync
    align_divider u_div (
        .clk_sys(clk_sys),
        .reset(reset),
        .tick(gen_tick),
        .restart(rel_pulse),
        .k_value(kdiv_q),
        .half_edge(div_edge)
    );

    // Request qualification; requests count only in internal mode
    always_comb begin
        sw_level = cfg.trig_bit | mode_q[SWREQ_BIT];
        sw_prev_d = sw_level;
        pin_prev_d = pin_s;
        if (!cfg.req_from_pin) begin
            start = sw_level & ~sw_prev_q;
            stop_level = ~sw_level;
        end else if (!cfg.edge_trig) begin
            start = pin_s & ~pin_prev_q;
            stop_level = ~pin_s;
        end else begin
            // Edge mode: trigger bit one picks rising, zero falling
            start = cfg.trig_bit ? (pin_s & ~pin_prev_q)
                                 : (~pin_s & pin_prev_q);
            stop_level = 1'b0;
        end
        start = start & internal &
                (cfg.out_mode == OUT_NSHOT || cfg.out_mode == OUT_CONT);
        stop_level = stop_level & (cfg.out_mode == OUT_CONT);
    end

    // Pattern state machine; output rises only on divider edges so pulses
    // stay aligned to the outputs however the request arrives
    always_comb begin
        state_d = state_q;
        gen_out_d = gen_out_q;
        pulses_d = pulses_q;
        nshot_done = 1'b0;
        case (state_q)
            GEN_IDLE: begin
                gen_out_d = 1'b0;
                pulses_d = 4'h0;
                if (start) begin
                    state_d = GEN_RUN;
                end
            end
            GEN_RUN: begin
                if (!internal || cfg.out_mode == OUT_STOP ||
                    cfg.out_mode == OUT_INVALID) begin
                    state_d = GEN_IDLE;
                    gen_out_d = 1'b0;
                end else if (div_edge) begin
                    if (gen_out_q) begin
                        gen_out_d = 1'b0;
                        pulses_d = pulses_q + 4'h1;
                        if (cfg.out_mode == OUT_NSHOT &&
                            pulses_q + 4'h1 >= n_target) begin
                            state_d = GEN_IDLE;
                            nshot_done = 1'b1;
                        end else if (stop_level) begin
                            state_d = GEN_IDLE;
                        end
                    end else if (stop_level) begin
                        state_d = GEN_IDLE;
                    end else begin
                        gen_out_d = 1'b1;
                    end
                end
            end
            default: begin
                state_d = GEN_IDLE;
                gen_out_d = 1'b0;
            end
        endcase
    end

    // Source select; retimed path samples only on the chosen clock enable
    always_comb begin
        ret_d = gen_tick ? ext_s : ret_q;
        case (cfg.src_mode)
            2'b00: out_d = ext_s;
            2'b01: out_d = ret_q;
            default: out_d = gen_out_q;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sw_prev_q <= 1'b0;
            pin_prev_q <= 1'b0;
            state_q <= GEN_IDLE;
            gen_out_q <= 1'b0;
            pulses_q <= 4'h0;
            ret_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            sw_prev_q <= sw_prev_d;
            pin_prev_q <= pin_prev_d;
            state_q <= state_d;
            gen_out_q <= gen_out_d;
            pulses_q <= pulses_d;
            ret_q <= ret_d;
            out_q <= out_d;
        end
    end

    assign align_out = out_q;
    assign reg_rdata = rdata_q;

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    // Helper: pulses emitted in the current sequence
    logic [3:0] seen_q;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            seen_q <= 4'h0;
        end else if (state_q == GEN_IDLE) begin
            seen_q <= 4'h0;
        end else if (gen_out_d && !gen_out_q) begin
            seen_q <= seen_q + 4'h1;
        end
    end

    sequence s_set_then_clear;
        sync_ctl_q[SYNC_BIT] ##1 !sync_ctl_q[SYNC_BIT];
    endsequence

    sequence s_nshot_end;
        (state_q == GEN_RUN && cfg.out_mode == OUT_NSHOT) ##1
        (state_q == GEN_IDLE);
    endsequence

    a_sync_on_fall: assert property (
        s_set_then_clear |=> channel_phase_apply)
        else $error("sync clear did not release dividers");

    a_hold_unignored: assert property (
        sync_ctl_q[SYNC_BIT] |=> ((channel_hold | ignore_vec) == '1))
        else $error("channel not held during sync");

    a_auto_once: assert property (
        first_done_q |=> (!auto_q && first_done_q))
        else $error("auto sync repeated after first lock");

    a_ext_no_run: assert property (
        !internal |=> state_q == GEN_IDLE)
        else $error("generator ran in external mode");

    a_stop_low: assert property (
        (cfg.out_mode == OUT_STOP) |=> ##1 !gen_out_q)
        else $error("stop mode output not low");

    a_pulse_count: assert property (
        s_nshot_end |-> !$past(nshot_done, 1) ||
        $past(seen_q, 1) == $past(n_target, 1))
        else $error("wrong N-shot pulse count");

    a_rise_aligned: assert property (
        $rose(gen_out_q) |-> $past(div_edge))
        else $error("pulse not aligned to divider edge");

    a_edge_ignored: assert property (
        (state_q == GEN_RUN && cfg.req_from_pin && cfg.edge_trig &&
         cfg.out_mode == OUT_NSHOT && internal && !div_edge)
        |=> state_q == GEN_RUN)
        else $error("edge mode sequence disturbed by pin");

    a_sw_clear: assert property (
        (nshot_done && !cfg.req_from_pin && !reg_wr) |=> !cfg.trig_bit)
        else $error("trigger bit not cleared after N-shot");

    a_cont_stop: assert property (
        (state_q == GEN_RUN && cfg.out_mode == OUT_CONT && internal &&
         !cfg.req_from_pin && !sw_level && div_edge) |=> state_q == GEN_IDLE)
        else $error("continuous run did not stop");

    a_retime_hold: assert property (
        (cfg.src_mode == 2'b01 && !gen_tick) |=> $stable(ret_q))
        else $error("retimer sampled without clock enable");
endmodule

// ### dv/align_partner.sv
// Far-side model: loop lock, external align source and request pin
`timescale 1ns/1ps
module align_partner (
    // Clock
    input wire logic clk_sys,
    // Lines driven toward the block
    output logic osc_tick,
    output logic fb_tick,
    output logic synth_lock,
    output logic ext_align,
    output logic req_pin
);
    int ph;

    // Quiet lines at time zero
    initial begin
        ph = 0;
        osc_tick = 1'b0;
        fb_tick = 1'b0;
        synth_lock = 1'b0;
        ext_align = 1'b0;
        req_pin = 1'b0;
    end

    // Oscillator enable every 2nd cycle, feedback every 3rd
    always @(posedge clk_sys) begin
        #1;
        ph = (ph + 1) % 6;
        osc_tick = (ph % 2 == 0);
        fb_tick = (ph % 3 == 0);
    end

    // Requests wait for lock so the generator clock is trustworthy
    task automatic set_pin(input logic v);
        wait (synth_lock === 1'b1);
        @(posedge clk_sys);
        #1 req_pin = v;
    endtask

    // Lock and external source change just after an edge
    task automatic set_lock(input logic v);
        @(posedge clk_sys);
        #1 synth_lock = v;
    endtask

    task automatic set_ext(input logic v);
        @(posedge clk_sys);
        #1 ext_align = v;
    endtask
endmodule

// ### dv/tb_top.sv
// Self-checking bench for output sync and align pulse generation
`timescale 1ns/1ps
module tb_top;
    import sysref_pkg::*;
    logic clk_sys;
    logic reset;
    logic [ADDR_W-1:0] reg_addr;
    logic reg_wr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic osc_tick, fb_tick, synth_lock, ext_align, req_pin;
    logic align_out, channel_phase_apply, hit;
    logic [NUM_CH-1:0] channel_hold, hsn;
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;
    int rises, width, n0;
    logic [2:0] codes[6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
    int npul[6] = '{1, 2, 4, 6, 8, 1};

    sysref_sync_top dut_u (.clk_sys(clk_sys), .reset(reset),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .osc_tick(osc_tick), .fb_tick(fb_tick),
        .synth_lock(synth_lock), .external_align_input(ext_align),
        .align_pulse_request_pin(req_pin), .align_out(align_out),
        .channel_hold(channel_hold),
        .channel_phase_apply(channel_phase_apply));
    align_partner p_u (.clk_sys(clk_sys), .osc_tick(osc_tick),
        .fb_tick(fb_tick), .synth_lock(synth_lock),
        .ext_align(ext_align), .req_pin(req_pin));

    // 250 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Hang guard, far above the roughly 1500 cycles the run needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (error_cnt == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // Register write: one-cycle strobe
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1 reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk_sys);
        #1 reg_wr = 1'b0;
    endtask

    // Register read: data registered one cycle behind the address
    task automatic rd(input logic [12:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        #1 reg_addr = a;
        repeat (2) @(posedge clk_sys);
        #1 chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask

    // Rising edges and widest high run of the align output
    task automatic watch(input int n);
        int run;
        logic prev;
        rises = 0;
        width = 0;
        run = 0;
        prev = align_out;
        repeat (n) begin
            @(posedge clk_sys);
            #1;
            if (align_out === 1'b1 && prev !== 1'b1)
                rises++;
            run = (align_out === 1'b1) ? run + 1 : 0;
            if (run > width)
                width = run;
            prev = align_out;
        end
    endtask

    // Look for a release pulse and capture the holds beside it
    task automatic wait_apply(input int n);
        hit = 1'b0;
        hsn = '0;
        repeat (n) begin
            @(posedge clk_sys);
            #1;
            if (channel_phase_apply === 1'b1 && hit === 1'b0) begin
                hit = 1'b1;
                hsn = channel_hold;
            end
        end
    endtask

    // Main sequence
    initial begin
        reset = 1'b1;
        reg_addr = '0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        repeat (20) @(posedge clk_sys);
        #1 reset = 1'b0;
        rd(OFS_OUT_SYNC, RST_OUT_SYNC);
        rd(OFS_MODE, RST_MODE);
        rd(13'h0100, 8'h00);
        wr(OFS_IGN_LO, 8'h05);
        rd(OFS_IGN_LO, 8'h05);
        p_u.set_lock(1'b1);
        wait_apply(10);
        chk({15'h0, hit}, 16'h0001);
        chk({2'b00, hsn}, 16'h3fff);
        p_u.set_lock(1'b0);
        p_u.set_lock(1'b1);
        wait_apply(10);
        chk({15'h0, hit}, 16'h0000);
        wr(OFS_IGN_HI, 8'h20);
        wr(OFS_OUT_SYNC, 8'h01);
        wait_apply(4);
        chk({15'h0, hit}, 16'h0000);
        chk({2'b00, channel_hold}, 16'h1ffa);
        wr(OFS_OUT_SYNC, 8'h00);
        wait_apply(6);
        chk({15'h0, hit}, 16'h0001);
        chk({2'b00, channel_hold}, 16'h0000);
        // External modes: requests have no effect
        p_u.set_pin(1'b1);
        watch(10);
        chk(16'(rises), 16'h0000);
        p_u.set_pin(1'b0);
        p_u.set_ext(1'b1);
        watch(6);
        chk({15'h0, align_out}, 16'h0001);
        p_u.set_ext(1'b0);
        watch(6);
        chk({15'h0, align_out}, 16'h0000);
        wr(OFS_MODE, 8'h40);
        wr(OFS_REQ_TRIG, 8'h10);
        p_u.set_ext(1'b1);
        watch(10);
        chk({15'h0, align_out}, 16'h0001);
        p_u.set_ext(1'b0);
        watch(10);
        // Internal generator, software N-shot for count codes 1 to 5 and 7
        wr(OFS_KDIV_LO, 8'h02);
        wr(OFS_KDIV_HI, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(OFS_REQ_TRIG, 8'h00);
            wr(OFS_MODE, {4'b1000, codes[i], 1'b0});
            wr(OFS_REQ_TRIG, 8'h20);
            watch(120);
            chk(16'(rises), 16'(npul[i]));
            chk(16'(width), 16'h0004);
            rd(OFS_REQ_TRIG, 8'h00);
        end
        // Request through the mode register bit, cleared when done
        wr(OFS_MODE, 8'h83);
        watch(40);
        chk(16'(rises), 16'h0001);
        rd(OFS_MODE, 8'h82);
        wr(OFS_MODE, 8'h90);
        wr(OFS_REQ_TRIG, 8'h20);
        watch(80);
        chk(16'(rises >= 9), 16'h0001);
        chk(16'(width), 16'h0004);
        rd(OFS_REQ_TRIG, 8'h21);
        wr(OFS_REQ_TRIG, 8'h00);
        watch(20);
        watch(40);
        chk(16'(rises), 16'h0000);
        wr(OFS_MODE, 8'hb0);
        wr(OFS_REQ_TRIG, 8'h20);
        watch(60);
        chk(16'(rises), 16'h0000);
        // Pin level trigger, N-shot then continuous
        wr(OFS_MODE, 8'h82);
        wr(OFS_REQ_TRIG, 8'h80);
        p_u.set_pin(1'b1);
        watch(60);
        chk(16'(rises), 16'h0001);
        p_u.set_pin(1'b0);
        wr(OFS_MODE, 8'h90);
        p_u.set_pin(1'b1);
        watch(40);
        chk(16'(rises >= 4), 16'h0001);
        p_u.set_pin(1'b0);
        watch(20);
        watch(40);
        chk(16'(rises), 16'h0000);
        // Pin edge trigger: rising, with a drop and re-edge mid-run
        wr(OFS_MODE, 8'h84);
        wr(OFS_REQ_TRIG, 8'he0);
        p_u.set_pin(1'b1);
        watch(8);
        n0 = rises;
        p_u.set_pin(1'b0);
        p_u.set_pin(1'b1);
        watch(60);
        chk(16'(n0 + rises), 16'h0002);
        wr(OFS_REQ_TRIG, 8'hc0);
        p_u.set_pin(1'b0);
        watch(60);
        chk(16'(rises), 16'h0002);
        // Reset with the loop still locked must sync once more
        @(posedge clk_sys);
        #1 reset = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 reset = 1'b0;
        wait_apply(10);
        chk({15'h0, hit}, 16'h0001);
        complete_run();
    end
endmodule
